// *** pkg/canmc_pkg.sv ***
/*
 * canmc_pkg: register map, field positions, mode codes and timing counts
 * for the CAN mode and control block.
 * Assumes a 32-bit classic Wishbone bus with byte addresses.
 */
package canmc_pkg;

   // register byte offsets
   localparam logic [7:0] CANMC_OFF_MODE  = 8'h00;
   localparam logic [7:0] CANMC_OFF_DCMP  = 8'h04;
   localparam logic [7:0] CANMC_OFF_INTERRUPT_CODE = 8'h08;
   localparam logic [7:0] CANMC_OFF_FIFO  = 8'h0c;
   localparam logic [7:0] CANMC_OFF_WAKE  = 8'h10;

   // mode_control field positions
   localparam int CANMC_B_STOP_IDLE = 13;
   localparam int CANMC_B_ABORT_ALL = 12;
   localparam int CANMC_B_REQ_LO    = 8;
   localparam int CANMC_B_CUR_LO    = 5;
   localparam int CANMC_B_CAPTURE   = 3;
   localparam int CANMC_B_WINDOW    = 0;
   // other field positions
   localparam int CANMC_B_FHIT_LO   = 8;
   localparam int CANMC_B_BCNT_LO   = 13;
   localparam int CANMC_B_WAKE_FILT = 14;

   // mode codes, shared by request and current-mode fields
   localparam logic [2:0] CANMC_MODE_NORMAL  = 3'h0;
   localparam logic [2:0] CANMC_MODE_DISABLE = 3'h1;
   localparam logic [2:0] CANMC_MODE_LOOP    = 3'h2;
   localparam logic [2:0] CANMC_MODE_LISTEN  = 3'h3;
   localparam logic [2:0] CANMC_MODE_CONFIG  = 3'h4;
   localparam logic [2:0] CANMC_MODE_RSVD5   = 3'h5;
   localparam logic [2:0] CANMC_MODE_RSVD6   = 3'h6;
   localparam logic [2:0] CANMC_MODE_LALL    = 3'h7;

   // field limits and reset values
   localparam logic [4:0] CANMC_DCMP_MAX     = 5'h11;
   localparam logic [4:0] CANMC_FHIT_MAX     = 5'h0f;
   localparam logic [6:0] CANMC_INTERRUPT_CODE_NONE   = 7'h40;
   localparam logic [6:0] CANMC_INTERRUPT_CODE_TOP    = 7'h44;
   localparam logic [6:0] CANMC_INTERRUPT_CODE_BUFMAX = 7'h0f;
   localparam logic [2:0] CANMC_BCNT_RSVD    = 3'h7;
   localparam logic [2:0] CANMC_MODE_RESET   = CANMC_MODE_CONFIG;

   // bus idle: consecutive recessive bits
   localparam logic [3:0] CANMC_IDLE_BITS = 4'd11;

   // wake-up low-pass filter: least stable time on the receive line
   localparam int CANMC_CLK_MHZ     = 40;
   localparam int CANMC_WAKE_FILT_NS = 200;
   localparam int CANMC_WAKE_FILT_CYC =
      (CANMC_WAKE_FILT_NS * CANMC_CLK_MHZ + 999) / 1000;

endpackage : canmc_pkg

// *** hdl/canmc_ctrl.sv ***
/*
 * canmc_ctrl: operating-mode controller and core control registers of a
 * CAN controller, with a classic Wishbone register slave.
 * Assumes the protocol engine gives a one-cycle sample pulse per bit,
 * reports frame activity, and keeps its own buffers, flags and counters.
 */
// The Wishbone register port and the register addresses were left to the implementer.
module canmc_ctrl
   import canmc_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // can pins
   input  wire logic        bus_receive_pin_i,
   output logic             bus_transmit_pin_o,
   output logic             bus_transmit_oe_o,
   output logic             bus_receive_own_o,
   // protocol engine
   input  wire logic        bit_sample_i,
   input  wire logic        eng_tx_i,
   output logic             eng_rx_o,
   input  wire logic        tx_in_progress_i,
   input  wire logic        tx_pending_i,
   input  wire logic        rx_msg_done_i,
   input  wire logic        rx_error_i,
   input  wire logic        all_aborted_i,
   input  wire logic [4:0]  filter_hit_i,
   input  wire logic [6:0]  interrupt_code_i,
   output logic             tx_enable_o,
   output logic             rx_enable_o,
   output logic             ack_err_enable_o,
   output logic             err_count_freeze_o,
   output logic             err_count_clear_o,
   output logic             listen_all_o,
   output logic             keep_partial_o,
   output logic             abort_all_o,
   output logic             start_abort_o,
   output logic             config_unlocked_o,
   // system
   input  wire logic        cpu_idle_i,
   input  wire logic        sleep_i,
   output logic             wake_event_o,
   output logic             capture_event_o,
   output logic             window_select_o,
   output logic [4:0]       data_compare_count_o,
   output logic [5:0]       buffer_count_o,
   output logic [4:0]       fifo_start_o
);
   import canmc_pkg::*;

   localparam int WFW = $clog2(CANMC_WAKE_FILT_CYC + 1);
   localparam logic [WFW-1:0] WAKE_FILT_CNT = WFW'(CANMC_WAKE_FILT_CYC);

   function automatic logic mode_reserved(input logic [2:0] m);
      mode_reserved = (m == CANMC_MODE_RSVD5) || (m == CANMC_MODE_RSVD6);
   endfunction : mode_reserved

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0]  s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction : merge16

   function automatic logic [5:0] decode_bcnt(input logic [2:0] c);
      unique case (c)
         3'h0:    decode_bcnt = 6'd4;
         3'h1:    decode_bcnt = 6'd6;
         3'h2:    decode_bcnt = 6'd8;
         3'h3:    decode_bcnt = 6'd12;
         3'h4:    decode_bcnt = 6'd16;
         3'h5:    decode_bcnt = 6'd24;
         default: decode_bcnt = 6'd32;
      endcase
   endfunction : decode_bcnt

   // registers
   logic [2:0]  requested_mode;
   logic [2:0]  current_mode;
   logic        stop_in_idle;
   logic        abort_all;
   logic        capture_link_enable;
   logic        window_select;
   logic        wake_filter_enable;
   logic [4:0]  data_compare_count;
   logic [4:0]  filter_hit;
   logic [6:0]  interrupt_code;
   logic [2:0]  buffer_count;
   logic [4:0]  fifo_start;

   // bus access decode
   logic        wr;
   logic        in_config;
   logic [15:0] wr_mode;
   logic [15:0] wr_dcmp;
   logic [15:0] wr_fifo;
   logic [15:0] wr_wake;

   assign wr        = cyc_i && stb_i && we_i && !ack_o;
   assign in_config = (current_mode == CANMC_MODE_CONFIG);
   assign wr_mode   = merge16({2'b0, stop_in_idle, abort_all, 1'b0, requested_mode,
                               current_mode, 1'b0, capture_link_enable, 2'b0,
                               window_select}, dat_i, sel_i);
   assign wr_dcmp   = merge16({11'b0, data_compare_count}, dat_i, sel_i);
   assign wr_fifo   = merge16({buffer_count, 8'b0, fifo_start}, dat_i, sel_i);
   assign wr_wake   = merge16({1'b0, wake_filter_enable, 14'b0}, dat_i, sel_i);

   // one-wait-state ack, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i)
         ack_o <= 1'b0;
      else
         ack_o <= cyc_i && stb_i && !ack_o;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0;
      end else if (cyc_i && stb_i && !ack_o) begin
         unique case (adr_i)
            CANMC_OFF_MODE:  dat_o <= {16'h0, 2'b0, stop_in_idle, abort_all, 1'b0,
                                       requested_mode, current_mode, 1'b0,
                                       capture_link_enable, 2'b0, window_select};
            CANMC_OFF_DCMP:  dat_o <= {27'h0, data_compare_count};
            CANMC_OFF_INTERRUPT_CODE: dat_o <= {19'h0, filter_hit, 1'b0, interrupt_code};
            CANMC_OFF_FIFO:  dat_o <= {16'h0, buffer_count, 8'h0, fifo_start};
            CANMC_OFF_WAKE:  dat_o <= {17'h0, wake_filter_enable, 14'h0};
            default:         dat_o <= 32'h0;
         endcase
      end
   end

   // mode request field, always writable
   always_ff @(posedge clk_i) begin
      if (rst_i)
         requested_mode <= CANMC_MODE_RESET;
      else if (wr && adr_i == CANMC_OFF_MODE && sel_i[1])
         requested_mode <= wr_mode[CANMC_B_REQ_LO +: 3];
   end

   // control bits of mode_control, locked outside configuration
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stop_in_idle        <= 1'b0;
         capture_link_enable <= 1'b0;
         window_select       <= 1'b0;
      end else if (wr && adr_i == CANMC_OFF_MODE && in_config) begin
         stop_in_idle        <= wr_mode[CANMC_B_STOP_IDLE];
         capture_link_enable <= wr_mode[CANMC_B_CAPTURE];
         window_select       <= wr_mode[CANMC_B_WINDOW];
      end
   end

   // abort-all: software set wins over hardware clear
   always_ff @(posedge clk_i) begin
      if (rst_i)
         abort_all <= 1'b0;
      else if (wr && adr_i == CANMC_OFF_MODE && sel_i[1] && wr_mode[CANMC_B_ABORT_ALL])
         abort_all <= 1'b1;
      else if (abort_all && all_aborted_i)
         abort_all <= 1'b0;
   end

   // locked configuration registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data_compare_count <= 5'h0;
         buffer_count       <= 3'h0;
         fifo_start         <= 5'h0;
         wake_filter_enable <= 1'b0;
      end else if (wr && in_config) begin
         if (adr_i == CANMC_OFF_DCMP && wr_dcmp[4:0] <= CANMC_DCMP_MAX)
            data_compare_count <= wr_dcmp[4:0];
         if (adr_i == CANMC_OFF_FIFO) begin
            if (wr_fifo[CANMC_B_BCNT_LO +: 3] != CANMC_BCNT_RSVD)
               buffer_count <= wr_fifo[CANMC_B_BCNT_LO +: 3];
            fifo_start <= wr_fifo[4:0];
         end
         if (adr_i == CANMC_OFF_WAKE)
            wake_filter_enable <= wr_wake[CANMC_B_WAKE_FILT];
      end
   end

   // interrupt source code and filter hit, reserved codes dropped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         filter_hit     <= 5'h0;
         interrupt_code <= CANMC_INTERRUPT_CODE_NONE;
      end else begin
         if (rx_msg_done_i && filter_hit_i <= CANMC_FHIT_MAX)
            filter_hit <= filter_hit_i;
         if (interrupt_code_i <= CANMC_INTERRUPT_CODE_BUFMAX ||
             (interrupt_code_i >= CANMC_INTERRUPT_CODE_NONE && interrupt_code_i <= CANMC_INTERRUPT_CODE_TOP))
            interrupt_code <= interrupt_code_i;
      end
   end

   // bus idle detector on bit samples
   logic [3:0] recessive_run;
   logic       bus_idle;
   logic       rx_line;
   logic       mode_change;

   assign bus_idle = (recessive_run == CANMC_IDLE_BITS);

   always_ff @(posedge clk_i) begin
      if (rst_i)
         recessive_run <= 4'h0;
      else if (mode_change)
         recessive_run <= 4'h0;
      else if (bit_sample_i) begin
         if (!rx_line)
            recessive_run <= 4'h0;
         else if (!bus_idle)
            recessive_run <= recessive_run + 4'h1;
      end
   end

   // mode change handshake
   logic module_active;
   logic change_ok;

   assign module_active = (current_mode != CANMC_MODE_CONFIG) &&
                          (current_mode != CANMC_MODE_DISABLE);
   assign change_ok     = (!module_active || bus_idle) &&
                          !(requested_mode == CANMC_MODE_CONFIG && tx_in_progress_i);
   assign mode_change   = (requested_mode != current_mode) &&
                          !mode_reserved(requested_mode) && change_ok;

   always_ff @(posedge clk_i) begin
      if (rst_i)
         current_mode <= CANMC_MODE_RESET;
      else if (mode_change)
         current_mode <= requested_mode;
   end

   // error counters cleared on configuration entry
   always_ff @(posedge clk_i) begin
      if (rst_i)
         err_count_clear_o <= 1'b0;
      else
         err_count_clear_o <= mode_change && requested_mode == CANMC_MODE_CONFIG;
   end

   // start-of-mode wait: 11 recessive bits before the first frame
   logic start_wait;

   always_ff @(posedge clk_i) begin
      if (rst_i)
         start_wait <= 1'b0;
      else if (mode_change)
         start_wait <= requested_mode == CANMC_MODE_NORMAL ||
                       requested_mode == CANMC_MODE_LOOP;
      else if (bus_idle || start_abort_o)
         start_wait <= 1'b0;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i)
         start_abort_o <= 1'b0;
      else
         start_abort_o <= start_wait && tx_pending_i && !start_abort_o &&
                          requested_mode == CANMC_MODE_DISABLE;
   end

   // wake-up receive filter
   logic [WFW-1:0] filt_cnt;
   logic           rx_filtered;
   logic           rx_filt_prev;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         filt_cnt    <= '0;
         rx_filtered <= 1'b1;
      end else if (!(wake_filter_enable && sleep_i)) begin
         filt_cnt    <= '0;
         rx_filtered <= bus_receive_pin_i;
      end else if (bus_receive_pin_i == rx_filtered) begin
         filt_cnt <= '0;
      end else if (filt_cnt == WAKE_FILT_CNT - 1'b1) begin
         filt_cnt    <= '0;
         rx_filtered <= bus_receive_pin_i;
      end else begin
         filt_cnt <= filt_cnt + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_filt_prev <= 1'b1;
         wake_event_o <= 1'b0;
      end else begin
         rx_filt_prev <= rx_filtered;
         wake_event_o <= rx_filt_prev && !rx_filtered &&
                         current_mode == CANMC_MODE_DISABLE;
      end
   end

   // mode-dependent engine and pin control
   logic halted;
   logic own_tx_pin;
   logic own_rx_pin;
   logic can_tx;
   logic can_rx;

   assign halted     = stop_in_idle && cpu_idle_i;
   assign own_tx_pin = !halted && (current_mode == CANMC_MODE_NORMAL ||
                                   current_mode == CANMC_MODE_LALL);
   assign own_rx_pin = !halted && (own_tx_pin || current_mode == CANMC_MODE_LISTEN);
   assign can_tx     = !halted && (current_mode == CANMC_MODE_NORMAL ||
                                   current_mode == CANMC_MODE_LOOP);
   assign can_rx     = !halted && (can_tx || current_mode == CANMC_MODE_LISTEN ||
                                   current_mode == CANMC_MODE_LALL);
   assign rx_line    = (current_mode == CANMC_MODE_LOOP) ? eng_tx_i : bus_receive_pin_i;
   assign eng_rx_o   = rx_line;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_transmit_pin_o <= 1'b1;
         bus_transmit_oe_o  <= 1'b0;
         bus_receive_own_o  <= 1'b0;
         tx_enable_o        <= 1'b0;
         rx_enable_o        <= 1'b0;
         ack_err_enable_o   <= 1'b0;
         err_count_freeze_o <= 1'b1;
         listen_all_o       <= 1'b0;
      end else begin
         bus_transmit_pin_o <= own_tx_pin ? eng_tx_i : 1'b1;
         bus_transmit_oe_o  <= own_tx_pin;
         bus_receive_own_o  <= own_rx_pin;
         tx_enable_o        <= can_tx;
         rx_enable_o        <= can_rx;
         ack_err_enable_o   <= current_mode == CANMC_MODE_NORMAL && !halted;
         err_count_freeze_o <= current_mode != CANMC_MODE_NORMAL &&
                               current_mode != CANMC_MODE_LOOP;
         listen_all_o       <= current_mode == CANMC_MODE_LALL;
      end
   end

   // event outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         keep_partial_o  <= 1'b0;
         capture_event_o <= 1'b0;
      end else begin
         keep_partial_o  <= rx_error_i && current_mode == CANMC_MODE_LALL && !halted;
         capture_event_o <= rx_msg_done_i && capture_link_enable;
      end
   end

   assign abort_all_o          = abort_all;
   assign config_unlocked_o    = in_config;
   assign window_select_o      = window_select;
   assign data_compare_count_o = data_compare_count;
   assign buffer_count_o       = decode_bcnt(buffer_count);
   assign fifo_start_o         = fifo_start;

endmodule : canmc_ctrl

// *** dv/canmc_node.sv ***
/*
 * canmc_node: far-side bus node model for the mode controller bench.
 * Assumes one clock; the bus line is pulled recessive when nobody drives it.
 */
module canmc_node (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // bus side
   input  wire logic tx_i,
   input  wire logic oe_i,
   input  wire logic hold_i,
   output logic      rx_o,
   output logic      smp_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] phase;
   always_ff @(posedge clk_i) begin
      if (rst_i)
         phase <= 2'h0;
      else
         phase <= phase + 2'h1;
   end
   // one sample point every four clocks
   assign smp_o = (phase == 2'h3);
   // wired-and: dominant from this node, or our bit while we own the pin
   assign rx_o = !hold_i && (!oe_i || tx_i);
endmodule : canmc_node

// *** dv/canmc_chk.sv ***
/*
 * canmc_chk: port-level checks of the mode controller.
 * Assumes it is bound to canmc_ctrl and sees only its ports.
 */
module canmc_chk (
   // clock, reset and bus
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       stb_i,
   input wire logic       we_i,
   // pins and engine
   input wire logic       bus_receive_pin_i,
   input wire logic       eng_tx_i,
   input wire logic       eng_rx_o,
   input wire logic       bus_transmit_oe_o,
   input wire logic       bus_receive_own_o,
   input wire logic       tx_in_progress_i,
   input wire logic       rx_msg_done_i,
   input wire logic       all_aborted_i,
   // mode outputs
   input wire logic       tx_enable_o,
   input wire logic       rx_enable_o,
   input wire logic       abort_all_o,
   input wire logic       config_unlocked_o,
   input wire logic       capture_event_o,
   input wire logic [4:0] data_compare_count_o,
   input wire logic [5:0] buffer_count_o
);
   import canmc_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_cfg_held;
      config_unlocked_o [*2];
   endsequence
   sequence s_abort_done;
      abort_all_o && all_aborted_i && !(stb_i && we_i);
   endsequence
   property p_reset_mode;
      $fell(rst_i) |-> config_unlocked_o;
   endproperty
   property p_cfg_quiet;
      s_cfg_held |-> !tx_enable_o && !rx_enable_o && !bus_transmit_oe_o;
   endproperty
   property p_cfg_entry;
      $rose(config_unlocked_o) |-> !$past(tx_in_progress_i);
   endproperty
   property p_lock;
      !config_unlocked_o |=> $stable(buffer_count_o) && $stable(data_compare_count_o);
   endproperty
   property p_loop;
      (eng_rx_o != bus_receive_pin_i) |-> eng_rx_o == eng_tx_i && !config_unlocked_o;
   endproperty
   property p_own;
      bus_transmit_oe_o |-> bus_receive_own_o;
   endproperty
   property p_abort_clear;
      s_abort_done |=> !abort_all_o;
   endproperty
   property p_capture;
      capture_event_o |-> $past(rx_msg_done_i);
   endproperty
   property p_dcmp;
      data_compare_count_o <= CANMC_DCMP_MAX;
   endproperty
   a_reset_mode: assert property (p_reset_mode)
      else $error("mode not config after reset");
   a_cfg_quiet: assert property (p_cfg_quiet)
      else $error("activity in config mode");
   a_cfg_entry: assert property (p_cfg_entry)
      else $error("config entered during transmission");
   a_lock: assert property (p_lock)
      else $error("locked field changed");
   a_loop: assert property (p_loop)
      else $error("internal rx not looped");
   a_own: assert property (p_own)
      else $error("tx owned without rx");
   a_abort_clear: assert property (p_abort_clear)
      else $error("abort-all not cleared");
   a_capture: assert property (p_capture)
      else $error("capture without message");
   a_dcmp: assert property (p_dcmp)
      else $error("invalid compare count");
endmodule : canmc_chk

bind canmc_ctrl canmc_chk canmc_chk_inst (.clk_i, .rst_i, .stb_i, .we_i, .bus_receive_pin_i,
   .eng_tx_i, .eng_rx_o, .bus_transmit_oe_o, .bus_receive_own_o, .tx_in_progress_i,
   .rx_msg_done_i, .all_aborted_i, .tx_enable_o, .rx_enable_o, .abort_all_o,
   .config_unlocked_o, .capture_event_o, .data_compare_count_o, .buffer_count_o);

// *** dv/tb.sv ***
/*
 * tb: self-checking bench of canmc_ctrl over classic Wishbone.
 * Assumes canmc_pkg, canmc_ctrl, canmc_node and the bound checker.
 */
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import canmc_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i, stb_i, we_i, ack_o, hold, eng_tx_i, eng_rx_o;
   logic [7:0] adr_i;
   logic [3:0] sel_i;
   logic [31:0] dat_i, dat_o, q;
   logic bus_receive_pin_i, bus_transmit_pin_o, bus_transmit_oe_o, bus_receive_own_o;
   logic bit_sample_i, tx_in_progress_i, tx_pending_i, rx_msg_done_i, rx_error_i;
   logic all_aborted_i, tx_enable_o, rx_enable_o, ack_err_enable_o, err_count_freeze_o;
   logic err_count_clear_o, listen_all_o, keep_partial_o, abort_all_o, start_abort_o;
   logic config_unlocked_o, cpu_idle_i, sleep_i, wake_event_o, capture_event_o;
   logic window_select_o;
   logic [4:0] filter_hit_i, data_compare_count_o, fifo_start_o;
   logic [6:0] interrupt_code_i;
   logic [5:0] buffer_count_o;
   int bad_count = 0, checked = 0, clrs = 0, aborts = 0, wakes = 0;

   canmc_ctrl canmc_ctrl_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
      .dat_o, .ack_o, .bus_receive_pin_i, .bus_transmit_pin_o, .bus_transmit_oe_o,
      .bus_receive_own_o, .bit_sample_i, .eng_tx_i, .eng_rx_o, .tx_in_progress_i,
      .tx_pending_i, .rx_msg_done_i, .rx_error_i, .all_aborted_i, .filter_hit_i,
      .interrupt_code_i, .tx_enable_o, .rx_enable_o, .ack_err_enable_o, .err_count_freeze_o,
      .err_count_clear_o, .listen_all_o, .keep_partial_o, .abort_all_o, .start_abort_o,
      .config_unlocked_o, .cpu_idle_i, .sleep_i, .wake_event_o, .capture_event_o,
      .window_select_o, .data_compare_count_o, .buffer_count_o, .fifo_start_o);
   canmc_node canmc_node_inst (.clk_i, .rst_i, .tx_i(bus_transmit_pin_o),
      .oe_i(bus_transmit_oe_o), .hold_i(hold), .rx_o(bus_receive_pin_i), .smp_o(bit_sample_i));

   always #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      clrs += int'(err_count_clear_o === 1'b1);
      aborts += int'(start_abort_o === 1'b1);
      wakes += int'(wake_event_o === 1'b1);
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      q = dat_o;
      chk(n < 50, 1, "ack");
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   // request a mode, then poll the current-mode field
   task automatic setm(input logic [2:0] m, input logic [2:0] exp);
      int n;
      n = 0;
      wb(1'b1, CANMC_OFF_MODE, {21'h0, m, 8'h0});
      do begin
         wb(1'b0, CANMC_OFF_MODE, 32'h0);
         n++;
      end while (q[7:5] !== exp && n < 40);
      chk(q[7:5], exp, "mode");
   endtask : setm

   task automatic t_status;
      logic [6:0] ic [3] = '{7'h44, 7'h0f, 7'h45};
      logic [6:0] ie [3] = '{7'h44, 7'h0f, 7'h0f};
      logic [4:0] fh [3] = '{5'h0f, 5'h10, 5'h03};
      logic [4:0] fe [3] = '{5'h0f, 5'h0f, 5'h03};
      wb(1'b0, CANMC_OFF_MODE, 32'h0);
      chk(q, 32'h480, "mode reset");
      wb(1'b0, CANMC_OFF_INTERRUPT_CODE, 32'h0);
      chk(q, 32'h40, "no source");
      wb(1'b1, 8'h14, 32'hffff);
      wb(1'b0, 8'h14, 32'h0);
      chk(q, 32'h0, "unmapped");
      wb(1'b1, CANMC_OFF_MODE, 32'h408);
      for (int i = 0; i < 3; i++) begin
         interrupt_code_i <= ic[i];
         filter_hit_i <= fh[i];
         rx_msg_done_i <= 1'b1;
         @(posedge clk_i);
         rx_msg_done_i <= 1'b0;
         @(posedge clk_i);
         chk(capture_event_o, 1, "capture");
         wb(1'b0, CANMC_OFF_INTERRUPT_CODE, 32'h0);
         chk(q, {19'h0, fe[i], 1'b0, ie[i]}, "source");
      end
      $display("test status done");
   endtask : t_status

   task automatic t_setup;
      int sz [8] = '{4, 6, 8, 12, 16, 24, 32, 32};
      for (int i = 0; i < 8; i++) begin
         wb(1'b1, CANMC_OFF_FIFO, {16'h0, 3'(i), 8'h0, 5'(31 - i)});
         chk(buffer_count_o, sz[i], "buffers");
         chk(fifo_start_o, 31 - i, "fifo start");
      end
      wb(1'b1, CANMC_OFF_DCMP, 32'h11);
      wb(1'b1, CANMC_OFF_DCMP, 32'h12);
      chk(data_compare_count_o, 5'h11, "compare");
      wb(1'b1, CANMC_OFF_WAKE, 32'h4000);
      wb(1'b0, CANMC_OFF_WAKE, 32'h0);
      chk(q, 32'h4000, "wake filter");
      wb(1'b1, CANMC_OFF_MODE, 32'h401);
      chk(window_select_o, 1, "window");
      $display("test setup done");
   endtask : t_setup

   task automatic t_modes;
      setm(3'b000, 3'b000);
      chk({bus_transmit_oe_o, bus_receive_own_o, tx_enable_o, rx_enable_o}, 4'hf, "normal");
      chk({ack_err_enable_o, err_count_freeze_o}, 2'b10, "normal errors");
      wb(1'b1, CANMC_OFF_FIFO, 32'h0);
      wb(1'b1, CANMC_OFF_MODE, 32'h1);
      chk({buffer_count_o, window_select_o}, {6'd32, 1'b0}, "locked");
      hold <= 1'b1;
      setm(3'b101, 3'b000);
      setm(3'b001, 3'b000);
      repeat (60) @(posedge clk_i);
      setm(3'b001, 3'b000);
      hold <= 1'b0;
      setm(3'b001, 3'b001);
      chk({bus_transmit_oe_o, bus_receive_own_o}, 2'b00, "disable pins");
      sleep_i <= 1'b1;
      hold <= 1'b1;
      repeat (4) @(posedge clk_i);
      hold <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk(wakes, 0, "glitch filtered");
      hold <= 1'b1;
      repeat (12) @(posedge clk_i);
      hold <= 1'b0;
      sleep_i <= 1'b0;
      chk(wakes, 1, "wake");
      setm(3'b010, 3'b010);
      eng_tx_i <= 1'b0;
      @(posedge clk_i);
      chk({eng_rx_o, bus_transmit_oe_o, bus_receive_own_o, bus_transmit_pin_o}, 4'h1, "loop");
      eng_tx_i <= 1'b1;
      setm(3'b011, 3'b011);
      chk({bus_transmit_oe_o, bus_receive_own_o}, 2'b01, "listen");
      chk({ack_err_enable_o, err_count_freeze_o, listen_all_o}, 3'b010, "listen errors");
      setm(3'b111, 3'b111);
      rx_error_i <= 1'b1;
      @(posedge clk_i);
      rx_error_i <= 1'b0;
      @(posedge clk_i);
      chk({keep_partial_o, listen_all_o, ack_err_enable_o}, 3'b110, "keep partial");
      setm(3'b001, 3'b001);
      setm(3'b000, 3'b000);
      hold <= 1'b1;
      tx_pending_i <= 1'b1;
      wb(1'b1, CANMC_OFF_MODE, 32'h100);
      repeat (8) @(posedge clk_i);
      chk(aborts, 1, "start abort");
      hold <= 1'b0;
      tx_pending_i <= 1'b0;
      setm(3'b001, 3'b001);
      setm(3'b000, 3'b000);
      tx_in_progress_i <= 1'b1;
      setm(3'b100, 3'b000);
      repeat (60) @(posedge clk_i);
      setm(3'b100, 3'b000);
      tx_in_progress_i <= 1'b0;
      setm(3'b100, 3'b100);
      chk(clrs, 1, "counter clear");
      wb(1'b1, CANMC_OFF_MODE, 32'h3400);
      chk(abort_all_o, 1, "abort set");
      all_aborted_i <= 1'b1;
      @(posedge clk_i);
      all_aborted_i <= 1'b0;
      @(posedge clk_i);
      chk(abort_all_o, 0, "abort clear");
      wb(1'b1, CANMC_OFF_MODE, 32'h2000);
      setm(3'b000, 3'b000);
      cpu_idle_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk(bus_transmit_oe_o, 0, "idle halt");
      cpu_idle_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk(bus_transmit_oe_o, 1, "idle resume");
      $display("test modes done");
   endtask : t_modes

   task automatic close_out;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : close_out

   initial begin
      {cyc_i, stb_i, we_i, hold, tx_in_progress_i, tx_pending_i, rx_msg_done_i} = '0;
      {rx_error_i, all_aborted_i, cpu_idle_i, sleep_i} = '0;
      eng_tx_i = 1'b1;
      adr_i = 8'h0;
      sel_i = 4'h3;
      dat_i = 32'h0;
      filter_hit_i = 5'h0;
      interrupt_code_i = 7'h40;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_status;
      t_setup;
      t_modes;
      close_out;
   end

   initial begin
      #(25 * 8000);
      bad_count++;
      $display("ERROR %0t watchdog expired", $time);
      close_out;
   end
endmodule : tb
